// ==== design/sssa_pkg.sv ====
package sssa_pkg;
  localparam int unsigned SSSA_ADDR_W    = 17;
  localparam int unsigned SSSA_BYTES     = 4;
  localparam int unsigned SSSA_BYTE_W    = 9;
  localparam int unsigned SSSA_DATA_W    = SSSA_BYTES * SSSA_BYTE_W;
  // Data cycle follows the load cycle by this many clocks
  localparam int unsigned SSSA_LATENCY   = 2;
  // Levels that undriven strap inputs settle to
  localparam logic        SSSA_BURST_DFLT = 1'b1;
  localparam logic        SSSA_SLEEP_DFLT = 1'b0;
endpackage

// ==== design/sssa_mem.sv ====
`timescale 1ns/100ps
module sssa_mem
  import sssa_pkg::*;
#(
  parameter int unsigned ADDR_W = SSSA_ADDR_W,
  parameter int unsigned BYTES  = SSSA_BYTES,
  parameter int unsigned BYTE_W = SSSA_BYTE_W
)
(
  input  wire logic                      sys_clk,
  input  wire logic                      rd_en,
  input  wire logic [ADDR_W-1:0]         rd_addr,
  output logic      [BYTES*BYTE_W-1:0]   rd_data,
  input  wire logic                      wr_en,
  input  wire logic [ADDR_W-1:0]         wr_addr,
  input  wire logic [BYTES-1:0]          wr_byte,
  input  wire logic [BYTES*BYTE_W-1:0]   wr_data
);

  ////////////////////////////////////////////////////////////////////////////
  // One array per byte lane, so that no array has two writing processes
  for (genvar g = 0; g < BYTES; g++)
  begin : g_lane
    logic [BYTE_W-1:0] lane_ff [0:(1<<ADDR_W)-1];
    logic [BYTE_W-1:0] q_ff;

    always_ff @(posedge sys_clk)
    begin
      if (wr_en && wr_byte[g])
      begin
        lane_ff[wr_addr] <= wr_data[g*BYTE_W +: BYTE_W];
      end
      if (rd_en)
      begin
        q_ff <= lane_ff[rd_addr];
      end
    end

    assign rd_data[g*BYTE_W +: BYTE_W] = q_ff;
  end

endmodule

// ==== design/sssa_top.sv ====
`timescale 1ns/100ps
// What this block does
// - Loaded read drives data two clocks later
// - Loaded write stores bus data two later
// - Deselect never cancels a pending read
// - Deselect never cancels a pending write
// - Deselect floats data bus two clocks later
// - Data outputs float as soon as reset is asserted
// - Undriven straps: burst high, sleep low
module sssa_top
  import sssa_pkg::*;
#(
  parameter int unsigned ADDR_W = SSSA_ADDR_W,
  parameter int unsigned BYTES  = SSSA_BYTES,
  parameter int unsigned BYTE_W = SSSA_BYTE_W
)
(
  input  wire logic                      sys_clk,
  input  wire logic                      arst_n,
  input  wire logic [ADDR_W-1:0]         address,
  input  wire logic                      read_write,
  input  wire logic                      advance_or_load,
  input  wire logic                      chip_select_a_n,
  input  wire logic                      chip_select_b,
  input  wire logic                      chip_select_c_n,
  input  wire logic                      clock_enable_n,
  input  wire logic [BYTES-1:0]          byte_write_n,
  input  wire logic                      output_enable_n,
  input  wire logic [BYTES*BYTE_W-1:0]   data_in,
  output logic      [BYTES*BYTE_W-1:0]   data_out,
  output logic                           data_oe,
  input  wire logic                      burst_order_select,
  input  wire logic                      burst_order_select_driven,
  input  wire logic                      sleep_request,
  input  wire logic                      sleep_request_driven,
  output logic                           burst_linear,
  output logic                           sleep_active
);

  localparam int unsigned DATA_W = BYTES * BYTE_W;

  if (ADDR_W < 1 || ADDR_W > 24 || BYTES < 1 || BYTE_W < 1)
  begin : g_bad_geometry
    $error("sssa_top: unsupported geometry");
  end

  typedef struct packed {
    logic burst;
    logic burst_drv;
    logic sleep;
    logic sleep_drv;
  } sssa_strap_t;

  typedef struct packed {
    logic              s1_valid;
    logic              s1_write;
    logic [ADDR_W-1:0] s1_addr;
    logic [BYTES-1:0]  s1_byte;
    logic              s2_write;
    logic [ADDR_W-1:0] s2_addr;
    logic [BYTES-1:0]  s2_byte;
    logic              oe;
    sssa_strap_t       strap_meta;
    sssa_strap_t       strap_sync;
    logic              linear;
    logic              sleep;
  } sssa_state_t;

  sssa_state_t st_ff;
  sssa_state_t nxt_st;

  logic advance;
  logic selected;
  logic sleep_eff;
  logic burst_eff;
  logic load_rd;
  logic load_wr;
  logic mem_rd;
  logic mem_we;

  ////////////////////////////////////////////////////////////////////////////
  // Decode of the sampled control

  assign selected  = !chip_select_a_n && chip_select_b && !chip_select_c_n;
  assign sleep_eff = st_ff.strap_sync.sleep_drv ? st_ff.strap_sync.sleep : SSSA_SLEEP_DFLT;
  assign burst_eff = st_ff.strap_sync.burst_drv ? st_ff.strap_sync.burst : SSSA_BURST_DFLT;

  assign advance = !clock_enable_n;
  assign load_rd = advance && selected && !advance_or_load && read_write && !sleep_eff;
  assign load_wr = advance && selected && !advance_or_load && !read_write
                   && !sleep_eff;
  assign mem_rd  = advance && st_ff.s1_valid && !st_ff.s1_write;
  assign mem_we  = advance && st_ff.s2_write;

  ////////////////////////////////////////////////////////////////////////////
  // Two-stage pipeline; stalls as a whole while clock_enable_n is high

  always_comb
  begin
    nxt_st                      = st_ff;
    // Straps are free-running pins: two flops before any use
    nxt_st.strap_meta.burst     = burst_order_select;
    nxt_st.strap_meta.burst_drv = burst_order_select_driven;
    nxt_st.strap_meta.sleep     = sleep_request;
    nxt_st.strap_meta.sleep_drv = sleep_request_driven;
    nxt_st.strap_sync           = st_ff.strap_meta;
    nxt_st.linear               = !burst_eff;
    nxt_st.sleep                = sleep_eff;
    if (advance)
    begin
      nxt_st.s1_valid = load_rd || load_wr;
      nxt_st.s1_write = load_wr;
      nxt_st.s1_addr  = address;
      nxt_st.s1_byte  = ~byte_write_n;
      nxt_st.s2_write = st_ff.s1_valid && st_ff.s1_write;
      nxt_st.s2_addr  = st_ff.s1_addr;
      nxt_st.s2_byte  = st_ff.s1_byte;
      // drive read data in data cycle
      nxt_st.oe       = mem_rd && !output_enable_n;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_ff <= '0;
      st_ff.linear <= !SSSA_BURST_DFLT;
      st_ff.sleep <= SSSA_SLEEP_DFLT;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  sssa_mem #(
    .ADDR_W (ADDR_W),
    .BYTES  (BYTES),
    .BYTE_W (BYTE_W)
  ) u_mem (
    .sys_clk (sys_clk),
    .rd_en   (mem_rd),
    .rd_addr (st_ff.s1_addr),
    .rd_data (data_out),
    .wr_en   (mem_we),
    .wr_addr (st_ff.s2_addr),
    .wr_byte (st_ff.s2_byte),
    .wr_data (data_in)
  );

  assign data_oe      = st_ff.oe;
  assign burst_linear = st_ff.linear;
  assign sleep_active = st_ff.sleep;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  property p_read_latency;
    @(posedge sys_clk) disable iff (!arst_n)
    load_rd ##1 (advance && !output_enable_n) |=> data_oe;
  endproperty
  a_read_latency: assert property (p_read_latency)
    else $error("read data not driven two clocks after load");

  property p_write_latency;
    @(posedge sys_clk) disable iff (!arst_n)
    load_wr ##1 advance ##1 advance |-> mem_we && st_ff.s2_addr == $past(address, 2);
  endproperty
  a_write_latency: assert property (p_write_latency)
    else $error("write not stored two clocks after load");

  property p_read_desel;
    @(posedge sys_clk) disable iff (!arst_n)
    load_rd ##1 (advance && !output_enable_n) ##1 !selected |-> data_oe;
  endproperty
  a_read_desel: assert property (p_read_desel)
    else $error("deselect cancelled a pending read");

  property p_write_desel;
    @(posedge sys_clk) disable iff (!arst_n)
    load_wr ##1 advance ##1 (advance && !selected) |-> mem_we;
  endproperty
  a_write_desel: assert property (p_write_desel)
    else $error("deselect cancelled a pending write");

  property p_desel_float;
    @(posedge sys_clk) disable iff (!arst_n)
    (advance && !selected && !advance_or_load) ##1 advance |=> !data_oe;
  endproperty
  a_desel_float: assert property (p_desel_float)
    else $error("bus driven two clocks after deselect");

  property p_reset_float;
    @(posedge sys_clk)
    !arst_n |-> !data_oe;
  endproperty
  a_reset_float: assert property (p_reset_float)
    else $error("data bus driven during reset");

  property p_sleep_default;
    @(posedge sys_clk) disable iff (!arst_n)
    !sleep_request_driven |-> ##3 !sleep_active;
  endproperty
  a_sleep_default: assert property (p_sleep_default)
    else $error("undriven sleep input did not default low");

  property p_burst_default;
    @(posedge sys_clk) disable iff (!arst_n)
    !burst_order_select_driven |-> ##3 !burst_linear;
  endproperty
  a_burst_default: assert property (p_burst_default)
    else $error("undriven burst order input did not default high");

  property p_partial_select;
    @(posedge sys_clk) disable iff (!arst_n)
    (advance && (chip_select_a_n || !chip_select_b || chip_select_c_n)) |=> !st_ff.s1_valid;
  endproperty
  a_partial_select: assert property (p_partial_select)
    else $error("access started with a select deasserted");

  property p_stall_hold;
    @(posedge sys_clk) disable iff (!arst_n)
    clock_enable_n |=> $stable(data_oe) && $stable(data_out);
  endproperty
  a_stall_hold: assert property (p_stall_hold)
    else $error("output changed while clock enable high");

endmodule

// ==== bench/sssa_ctrl.sv ====
`timescale 1ns/100ps
module sssa_ctrl
  import sssa_pkg::*;
(
  output logic [SSSA_ADDR_W-1:0] address,
  output logic                   read_write,
  output logic                   advance_or_load,
  output logic                   chip_select_a_n,
  output logic                   chip_select_b,
  output logic                   chip_select_c_n,
  output logic                   clock_enable_n,
  output logic [SSSA_BYTES-1:0]  byte_write_n,
  output logic                   output_enable_n,
  output logic [SSSA_DATA_W-1:0] data_in
);
  logic [SSSA_DATA_W:0] pend [0:2];

  initial
  begin
    {address, read_write, advance_or_load, clock_enable_n, output_enable_n} = '0;
    {chip_select_a_n, chip_select_b, chip_select_c_n} = 3'h5;
    byte_write_n = '1;
    data_in = '0;
    pend = '{default: '0};
  end

  ////////////////////////////////////////////////////////////////////////////////
  // One call is one clock cycle, entered just after a falling edge
  task automatic drv(input logic [2:0] sel, input logic rw,
                     input logic [SSSA_ADDR_W-1:0] a, input logic [SSSA_DATA_W-1:0] d);
    {chip_select_a_n, chip_select_b, chip_select_c_n} = sel;
    read_write = rw;
    address = a;
    byte_write_n = {SSSA_BYTES{rw}};
    pend[2] = pend[1];
    pend[1] = pend[0];
    pend[0] = {~rw, d};
    data_in = pend[2][SSSA_DATA_W] ? pend[2][SSSA_DATA_W-1:0] : ~data_in;
  endtask

  // Levels that stay put across cycles until changed
  task automatic pins(input logic ce_n, input logic oe_n, input logic aol);
    clock_enable_n = ce_n;
    output_enable_n = oe_n;
    advance_or_load = aol;
  endtask
endmodule

// ==== bench/sync_sram_select_access_tb_top.sv ====
`timescale 1ns/100ps
module sync_sram_select_access_tb_top;
  import sssa_pkg::*;
  localparam logic [2:0] SEL = 3'h2;
  localparam logic [2:0] OFF = 3'h5;
  logic                   sys_clk = 1'b0;
  logic                   arst_n = 1'b0;
  logic                   burst_order_select = 1'b0;
  logic                   burst_order_select_driven = 1'b0;
  logic                   sleep_request = 1'b1;
  logic                   sleep_request_driven = 1'b0;
  logic [SSSA_ADDR_W-1:0] address;
  logic                   read_write;
  logic                   advance_or_load;
  logic                   chip_select_a_n;
  logic                   chip_select_b;
  logic                   chip_select_c_n;
  logic                   clock_enable_n;
  logic [SSSA_BYTES-1:0]  byte_write_n;
  logic                   output_enable_n;
  logic [SSSA_DATA_W-1:0] data_in;
  logic [SSSA_DATA_W-1:0] data_out;
  logic                   data_oe;
  logic                   burst_linear;
  logic                   sleep_active;
  int                     num_errors = 0;
  int                     check_count = 0;

  sssa_top uut (
    .sys_clk                   (sys_clk),
    .arst_n                    (arst_n),
    .address                   (address),
    .read_write                (read_write),
    .advance_or_load           (advance_or_load),
    .chip_select_a_n           (chip_select_a_n),
    .chip_select_b             (chip_select_b),
    .chip_select_c_n           (chip_select_c_n),
    .clock_enable_n            (clock_enable_n),
    .byte_write_n              (byte_write_n),
    .output_enable_n           (output_enable_n),
    .data_in                   (data_in),
    .data_out                  (data_out),
    .data_oe                   (data_oe),
    .burst_order_select        (burst_order_select),
    .burst_order_select_driven (burst_order_select_driven),
    .sleep_request             (sleep_request),
    .sleep_request_driven      (sleep_request_driven),
    .burst_linear              (burst_linear),
    .sleep_active              (sleep_active)
  );
  sssa_ctrl ctl (
    .address         (address),
    .read_write      (read_write),
    .advance_or_load (advance_or_load),
    .chip_select_a_n (chip_select_a_n),
    .chip_select_b   (chip_select_b),
    .chip_select_c_n (chip_select_c_n),
    .clock_enable_n  (clock_enable_n),
    .byte_write_n    (byte_write_n),
    .output_enable_n (output_enable_n),
    .data_in         (data_in)
  );

  always #5 sys_clk = ~sys_clk;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic cy(input logic [2:0] sel, input logic rw,
                    input logic [SSSA_ADDR_W-1:0] a, input logic [SSSA_DATA_W-1:0] d);
    @(negedge sys_clk);
    ctl.drv(sel, rw, a, d);
  endtask

  task automatic idle(input int n);
    repeat (n) cy(OFF, 1'h1, '0, '0);
  endtask

  task automatic chk(input string nm, input logic [SSSA_DATA_W-1:0] exp,
                     input logic [SSSA_DATA_W-1:0] got);
    check_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got);
    end
  endtask

  task automatic summarize();
    $display("mismatches %0d comparisons %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_power();
    idle(2);
    chk("data_oe", 1'h0, data_oe);
  endtask

  // Write then read back, each data cycle deselected
  task automatic t_wr_rd();
    cy(SEL, 1'h0, 17'h1A5A5, 36'h9A5C3E1F7);
    idle(2);
    cy(SEL, 1'h1, 17'h1A5A5, '0);
    idle(2);
    chk("data_oe", 1'h1, data_oe);
    chk("data_out", 36'h9A5C3E1F7, data_out);
    idle(1);
    chk("data_oe", 1'h0, data_oe);
  endtask

  task automatic t_sel();
    for (int i = 0; i < 8; i++)
    begin
      cy(i[2:0], 1'h1, 17'h1A5A5, '0);
      idle(2);
      chk("data_oe", (i[2:0] == SEL), data_oe);
    end
  endtask

  task automatic t_strap();
    idle(2);
    chk("burst_linear", 1'h0, burst_linear);
    chk("sleep_active", 1'h0, sleep_active);
    burst_order_select_driven = 1'b1;
    sleep_request_driven = 1'b1;
    idle(3);
    chk("burst_linear", 1'h1, burst_linear);
    chk("sleep_active", 1'h1, sleep_active);
  endtask

  // Read data must stand while the clock enable stalls the pipeline
  task automatic t_stall();
    cy(SEL, 1'h1, 17'h1A5A5, '0);
    idle(2);
    ctl.pins(1'b1, 1'b0, 1'b0);
    idle(1);
    chk("data_oe", 1'h1, data_oe);
    chk("data_out", 36'h9A5C3E1F7, data_out);
    idle(1);
    ctl.pins(1'b0, 1'b0, 1'b0);
    idle(1);
    chk("data_oe", 1'h0, data_oe);
  endtask

  // Output enable high and load strobe high both keep the bus quiet
  task automatic t_gate();
    cy(SEL, 1'h1, 17'h1A5A5, '0);
    ctl.pins(1'b0, 1'b1, 1'b0);
    idle(2);
    chk("data_oe", 1'h0, data_oe);
    ctl.pins(1'b0, 1'b0, 1'b1);
    cy(SEL, 1'h1, 17'h1A5A5, '0);
    idle(2);
    chk("data_oe", 1'h0, data_oe);
    ctl.pins(1'b0, 1'b0, 1'b0);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    arst_n = 1'b1;
    t_power();
    t_wr_rd();
    t_sel();
    t_stall();
    t_gate();
    t_strap();
    summarize();
  end

  initial
  begin
    #20000;
    num_errors++;
    summarize();
  end
endmodule
